// ===== src/spso_pkg.sv
// Shared constants and carrier types for the print serial output block.
// Assumes a single 200 MHz core clock and a synchronous active-low reset.
package spso_pkg;

  // ----------------------------------------
  // Clock and bit rates
  // ----------------------------------------
  localparam int unsigned CLK_HZ_DEFAULT = 200_000_000;
  localparam int unsigned BAUD_300 = 300;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int DIV_W = 20;

  // ----------------------------------------
  // Character frame
  // ----------------------------------------
  localparam int DATA_BITS = 7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
  localparam logic [3:0] PARITY_BIT_IDX = 4'h8;
  localparam logic [3:0] RX_LAST_SHIFT = 4'h7;
  localparam logic [6:0] STX_CHAR = 7'h02;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------
  // Weight thresholds, in half increments
  // ----------------------------------------
  localparam int WEIGHT_W = 24;
  localparam logic signed [23:0] AUTO_MIN_HALF_D = 24'sh00000a;
  localparam logic signed [23:0] ZERO_BAND_HALF_D = 24'sh000001;

  typedef enum logic [2:0] {BAUD_SEL_300, BAUD_SEL_1200, BAUD_SEL_2400, BAUD_SEL_4800, BAUD_SEL_9600} spso_baud_t;
  typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_ZERO} spso_parity_t;

  typedef struct packed {
    spso_baud_t baud_rate_setting;
    spso_parity_t parity_choice_setting;
    logic checksum_enable_setting;
    logic autoprint_enable_setting;
    logic continuous_mode;
  } spso_cfg_t;

  typedef struct packed {
    logic in_motion;
    logic below_gross_zero;
    logic expanded_mode;
    logic zero_captured;
    logic signed [23:0] weight_half_d;
  } spso_scale_t;

  typedef struct packed {
    logic msg_end;
    logic cks_after;
    logic [6:0] chr;
  } spso_word_t;

endpackage

// ===== src/spso_fifo.sv
// Character FIFO between the message formatter and the transmitter.
// Assumes DEPTH is a power of two; both sides share core_clk.
`timescale 1ns/100ps
module spso_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid && ready_q;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    // Registered so the formatter sees a clean flop-driven stall
    ready_d = cnt_d != FULL_CNT;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  assign in_ready = ready_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  count_bound_a: assert property (@(posedge core_clk) disable iff (!reset_n) cnt_q <= FULL_CNT)
    else $error("fifo count above depth");

endmodule // spso_fifo

// ===== src/spso_rx.sv
// Receiver for the bidirectional terminal's receive pin.
// Assumes the pin is asynchronous; bit_div is the bit period in core_clk cycles.
`timescale 1ns/100ps
module spso_rx (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rxd_pin,
  input wire logic [spso_pkg::DIV_W-1:0] bit_div,
  output logic rx_valid,
  output logic [6:0] rx_char,
  output logic rx_frame_err
);
  import spso_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} spso_rx_state_t;

  logic s1_q, s2_q, s3_q, line_q, line_d;
  spso_rx_state_t st_q, st_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic [3:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d;
  logic valid_q, valid_d, err_q, err_d;
  logic [6:0] char_q, char_d;

  always_comb
  begin
    // A level change is accepted once the second and third stages agree
    line_d = (s2_q == s3_q) ? s3_q : line_q;
    st_d = st_q;
    cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
    idx_d = idx_q;
    sh_d = sh_q;
    valid_d = 1'b0;
    err_d = err_q;
    char_d = char_q;
    case (st_q)
      RX_IDLE:
        if (!line_q)
        begin
          st_d = RX_START;
          cnt_d = bit_div >> 1;
        end
      RX_START:
        if (cnt_q == '0)
        begin
          st_d = line_q ? RX_IDLE : RX_BITS;
          cnt_d = bit_div - 1'b1;
          idx_d = '0;
        end
      RX_BITS:
        if (cnt_q == '0)
        begin
          sh_d = {line_q, sh_q[7:1]};
          idx_d = idx_q + 1'b1;
          cnt_d = bit_div - 1'b1;
          if (idx_q == RX_LAST_SHIFT)
            st_d = RX_STOP;
        end
      RX_STOP:
        if (cnt_q == '0)
        begin
          st_d = RX_IDLE;
          valid_d = 1'b1;
          char_d = sh_q[6:0];
          err_d = !line_q;
        end
      default: st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      line_q <= 1'b1;
      st_q <= RX_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      sh_q <= '0;
      valid_q <= 1'b0;
      err_q <= 1'b0;
      char_q <= '0;
    end
    else
    begin
      s1_q <= rxd_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      line_q <= line_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      valid_q <= valid_d;
      err_q <= err_d;
      char_q <= char_d;
    end
  end

  assign rx_valid = valid_q;
  assign rx_char = char_q;
  assign rx_frame_err = err_q;

  rx_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n) valid_q |=> !valid_q)
    else $error("receive strobe longer than one cycle");

endmodule // spso_rx

// ===== src/spso_print_out.sv
// Print request handling and serial message output of the weighing indicator.
// Assumes a formatter that fills the character FIFO after print_start,
// scale status and settings on core_clk, and asynchronous serial pins.
//
// How it works
// - Ten-bit frame: start, seven data, parity, stop
// - Parity even, odd or forced zero
// - Bit rate 300, 1200, 2400, 4800, 9600
// - One setting enables checksum and, in demand mode only, leading STX
// - Print key, serial input, remote switch, autoprint
// - Hold request during motion, send when settled
// - Drop print below zero, expanded, zero uncaptured
// - Autoprint rearms only within half increment zero
// - Settled weight of five increments triggers autoprint
// - Autoprint works in demand and continuous modes
// - Both transmit and receive paths exist
// - Printer port transmit only; receive on terminal
// - Slow strip printer needs 300 baud both ends
// - Checksum is negated seven-bit sum of line
// - Start-of-text 02 hex sent first when enabled in demand mode
`timescale 1ns/100ps
module spso_print_out #(
  parameter int unsigned CLK_HZ = spso_pkg::CLK_HZ_DEFAULT,
  parameter int FIFO_DEPTH_P = spso_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire spso_pkg::spso_cfg_t cfg,
  input wire spso_pkg::spso_scale_t scale,
  input wire logic key_print,
  input wire logic remote_print_sw,
  input wire logic term_rxd,
  input wire logic msg_valid,
  output logic msg_ready,
  input wire spso_pkg::spso_word_t msg_word,
  output logic print_start,
  output logic print_busy,
  output logic printer_txd,
  output logic term_txd,
  output logic rx_valid,
  output logic [6:0] rx_char,
  output logic rx_frame_err
);
  import spso_pkg::*;

  // ----------------------------------------
  // Bit period selection
  // ----------------------------------------
  localparam logic [DIV_W-1:0] DIV_300 = DIV_W'(CLK_HZ / BAUD_300);
  localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'(CLK_HZ / BAUD_1200);
  localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'(CLK_HZ / BAUD_2400);
  localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'(CLK_HZ / BAUD_4800);
  localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / BAUD_9600);

  typedef enum logic [1:0] {ST_IDLE, ST_STX, ST_DATA, ST_CKS} spso_state_t;

  function automatic logic par_of(input logic [6:0] c, input spso_parity_t p);
    case (p)
      PAR_EVEN: par_of = ^c;
      PAR_ODD: par_of = ~^c;
      default: par_of = 1'b0;
    endcase
  endfunction

  logic [DIV_W-1:0] bit_div_q, bit_div_d;
  logic sw_s1_q, sw_s2_q, sw_s3_q, sw_lvl_q, sw_lvl_d;
  logic pend_q, pend_d, armed_q, armed_d;
  spso_state_t st_q, st_d;
  logic [6:0] sum_q, sum_d;
  logic end_q, end_d, start_q, start_d, busy_q, busy_d;
  logic tx_busy_q, tx_busy_d, txd_q, txd_d, par_q, par_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [DIV_W-1:0] tx_div_q, tx_div_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic tx_load, fifo_pop, fifo_valid, req_any, remote_rise, auto_fire, near_zero, inhibit, rx_ok;
  logic [6:0] ld_char;
  logic [8:0] fifo_out;
  spso_word_t head;

  // ----------------------------------------
  // Character FIFO and receiver
  // ----------------------------------------
  spso_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH_P)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(msg_valid),
    .in_ready(msg_ready),
    .in_data(msg_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // Receive only on the terminal pin; the printer port has no input
  spso_rx u_rx (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rxd_pin(term_rxd),
    .bit_div(bit_div_q),
    .rx_valid(rx_valid),
    .rx_char(rx_char),
    .rx_frame_err(rx_frame_err)
  );

  assign head = spso_word_t'(fifo_out);

  // ----------------------------------------
  // Print request sources
  // ----------------------------------------
  always_comb
  begin
    case (cfg.baud_rate_setting)
      BAUD_SEL_300: bit_div_d = DIV_300;
      BAUD_SEL_1200: bit_div_d = DIV_1200;
      BAUD_SEL_2400: bit_div_d = DIV_2400;
      BAUD_SEL_4800: bit_div_d = DIV_4800;
      default: bit_div_d = DIV_9600;
    endcase
    sw_lvl_d = (sw_s2_q == sw_s3_q) ? sw_s3_q : sw_lvl_q;
    remote_rise = (sw_s2_q == sw_s3_q) && sw_s3_q && !sw_lvl_q;
    rx_ok = rx_valid && !rx_frame_err;
    near_zero = (scale.weight_half_d <= ZERO_BAND_HALF_D) && (scale.weight_half_d >= -ZERO_BAND_HALF_D);
    // Autoprint ignores the output mode, so it serves demand and continuous alike
    auto_fire = cfg.autoprint_enable_setting && armed_q && !scale.in_motion
      && (scale.weight_half_d >= AUTO_MIN_HALF_D);
    armed_d = armed_q;
    if (auto_fire)
      armed_d = 1'b0;
    else if (near_zero)
      armed_d = 1'b1;
    req_any = key_print || remote_rise || rx_ok || auto_fire;
    inhibit = scale.below_gross_zero || scale.expanded_mode || !scale.zero_captured;
  end

  // ----------------------------------------
  // Message sequencer
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    pend_d = pend_q;
    sum_d = sum_q;
    end_d = end_q;
    start_d = 1'b0;
    tx_load = 1'b0;
    ld_char = '0;
    fifo_pop = 1'b0;
    case (st_q)
      ST_IDLE:
        if (pend_q && !scale.in_motion)
        begin
          pend_d = 1'b0;
          if (!inhibit)
          begin
            start_d = 1'b1;
            sum_d = '0;
            end_d = 1'b0;
            // Leading STX belongs to demand output only
            st_d = (cfg.checksum_enable_setting && !cfg.continuous_mode) ? ST_STX : ST_DATA;
          end
        end
      ST_STX:
        if (!tx_busy_q)
        begin
          tx_load = 1'b1;
          ld_char = STX_CHAR;
          sum_d = sum_q + STX_CHAR;
          st_d = ST_DATA;
        end
      ST_DATA:
        if (!tx_busy_q && fifo_valid)
        begin
          fifo_pop = 1'b1;
          tx_load = 1'b1;
          ld_char = head.chr;
          sum_d = sum_q + head.chr;
          end_d = head.msg_end;
          if (head.cks_after && cfg.checksum_enable_setting)
            st_d = ST_CKS;
          else if (head.msg_end)
            st_d = ST_IDLE;
        end
      ST_CKS:
        if (!tx_busy_q)
        begin
          tx_load = 1'b1;
          ld_char = 7'(~sum_q + 7'h01);
          sum_d = sum_q + ld_char;
          st_d = end_q ? ST_IDLE : ST_DATA;
        end
      default: st_d = ST_IDLE;
    endcase
    // A new request in the cycle the old one is taken is kept
    if (req_any)
      pend_d = 1'b1;
    busy_d = (st_d != ST_IDLE) || tx_busy_d;
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  always_comb
  begin
    tx_busy_d = tx_busy_q;
    tx_bit_d = tx_bit_q;
    tx_div_d = tx_div_q;
    tx_sh_d = tx_sh_q;
    txd_d = txd_q;
    par_d = par_q;
    if (tx_load)
    begin
      par_d = par_of(ld_char, cfg.parity_choice_setting);
      tx_sh_d = {1'b1, par_d, ld_char, 1'b0};
      tx_busy_d = 1'b1;
      tx_bit_d = '0;
      tx_div_d = bit_div_q - 1'b1;
      txd_d = 1'b0;
    end
    else if (tx_busy_q)
    begin
      if (tx_div_q == '0)
      begin
        tx_div_d = bit_div_q - 1'b1;
        if (tx_bit_q == FRAME_LAST_BIT)
        begin
          tx_busy_d = 1'b0;
          txd_d = 1'b1;
        end
        else
        begin
          tx_bit_d = tx_bit_q + 1'b1;
          tx_sh_d = tx_sh_q >> 1;
          txd_d = tx_sh_q[1];
        end
      end
      else
        tx_div_d = tx_div_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      bit_div_q <= '0;
      sw_s1_q <= 1'b0;
      sw_s2_q <= 1'b0;
      sw_s3_q <= 1'b0;
      sw_lvl_q <= 1'b0;
      pend_q <= 1'b0;
      armed_q <= 1'b1;
      st_q <= ST_IDLE;
      sum_q <= '0;
      end_q <= 1'b0;
      start_q <= 1'b0;
      busy_q <= 1'b0;
      tx_busy_q <= 1'b0;
      tx_bit_q <= '0;
      tx_div_q <= '0;
      tx_sh_q <= '1;
      txd_q <= 1'b1;
      par_q <= 1'b0;
    end
    else
    begin
      bit_div_q <= bit_div_d;
      sw_s1_q <= remote_print_sw;
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      sw_lvl_q <= sw_lvl_d;
      pend_q <= pend_d;
      armed_q <= armed_d;
      st_q <= st_d;
      sum_q <= sum_d;
      end_q <= end_d;
      start_q <= start_d;
      busy_q <= busy_d;
      tx_busy_q <= tx_busy_d;
      tx_bit_q <= tx_bit_d;
      tx_div_q <= tx_div_d;
      tx_sh_q <= tx_sh_d;
      txd_q <= txd_d;
      par_q <= par_d;
    end
  end

  // Both connectors carry the same transmit stream
  assign printer_txd = txd_q;
  assign term_txd = txd_q;
  assign print_start = start_q;
  assign print_busy = busy_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_load;
    tx_load;
  endsequence
  sequence s_start_bit;
    !txd_q && tx_busy_q && tx_bit_q == 4'h0;
  endsequence

  start_bit_a: assert property (s_load |=> s_start_bit)
    else $error("frame did not open with a start bit");
  stop_bit_a: assert property ($fell(tx_busy_q) |-> $past(txd_q) && $past(tx_bit_q) == FRAME_LAST_BIT)
    else $error("frame did not end with stop bit ten");
  idle_mark_a: assert property (!tx_busy_q |-> txd_q)
    else $error("line not at mark while idle");
  parity_bit_a: assert property (tx_busy_q && tx_bit_q == PARITY_BIT_IDX |-> txd_q == par_q)
    else $error("parity bit wrong on line");
  parity_calc_a: assert property (s_load |=> par_q == par_of($past(ld_char), $past(cfg.parity_choice_setting)))
    else $error("parity not taken from setting");
  // The period register reloads on every edge but holds zero in reset, so the first edge after reset is skipped
  baud_slow_a: assert property ($past(reset_n) && $past(cfg.baud_rate_setting) == BAUD_SEL_300
    |-> bit_div_q == DIV_300)
    else $error("300 baud period wrong");
  baud_fast_a: assert property ($past(reset_n) && $past(cfg.baud_rate_setting) == BAUD_SEL_9600
    |-> bit_div_q == DIV_9600)
    else $error("9600 baud period wrong");
  motion_hold_a: assert property (st_q == ST_IDLE && scale.in_motion |=> st_q == ST_IDLE && !start_q)
    else $error("print started during motion");
  inhibit_drop_a: assert property (st_q == ST_IDLE && pend_q && !scale.in_motion && inhibit && !req_any
    |=> !pend_q && st_q == ST_IDLE && !start_q)
    else $error("print not suppressed");
  rearm_hold_a: assert property (!armed_q && !near_zero |=> !armed_q)
    else $error("autoprint rearmed away from zero");
  auto_start_a: assert property (cfg.autoprint_enable_setting && armed_q && !scale.in_motion
    && scale.weight_half_d >= AUTO_MIN_HALF_D |=> pend_q && !armed_q)
    else $error("settled weight did not request print");
  // Checked per cycle: at slow rates the wait for a busy line is far beyond any delay range
  stx_first_a: assert property (st_q == ST_STX
    |-> !fifo_pop && (tx_busy_q || (tx_load && ld_char == STX_CHAR)))
    else $error("start of text not sent first");
  cks_value_a: assert property (tx_load && st_q == ST_CKS |-> 7'(ld_char + sum_q) == 7'h00)
    else $error("checksum does not cancel line sum");
  stx_gate_a: assert property (start_q && !cfg.checksum_enable_setting |-> st_q == ST_DATA)
    else $error("start of text sent while checksum off");

endmodule // spso_print_out

// ===== test/spso_serial_peer.sv
// Far-side model: a printer or host on the asynchronous link.
// Assumes bit_div (core_clk cycles per bit) is set by the bench before traffic.
`timescale 1ns/100ps
module spso_serial_peer (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic [31:0] bit_div,
  output logic rxd
);
  logic [9:0] frames[$];
  int lens[$];
  logic [9:0] bits;
  int rise;

  initial rxd = 1'b1;

  // ----------------------------------------
  // Receive: sample each bit at its middle
  // ----------------------------------------
  // The start length is the first low run, so it is exact only when d0 is 1
  always
  begin
    @(negedge txd);
    rise = 0;
    for (int c = 1; c <= 9 * bit_div + bit_div / 2; c++)
    begin
      @(posedge core_clk);
      #1;
      if (txd === 1'b1 && rise == 0)
        rise = c;
      if (c % bit_div == bit_div / 2)
        bits[c / bit_div] = txd;
    end
    frames.push_back(bits);
    lens.push_back(rise);
  end

  // ----------------------------------------
  // Send: even parity, LSB first, idle high
  // ----------------------------------------
  task automatic send_char(input logic [6:0] ch, input logic stop);
    logic [9:0] f;
    f = {stop, ^ch, ch, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      rxd <= f[i];
      repeat (bit_div - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rxd <= 1'b1;
  endtask
endmodule // spso_serial_peer

// ===== test/spso_print_out_test.sv
// Self-checking bench for the print serial output block.
// Assumes the bench plays the formatter; bit periods shortened by CLK_HZ.
`timescale 1ns/100ps
module spso_print_out_test;
  import spso_pkg::*;
  localparam int unsigned TB_CLK = 200_000;
  localparam int unsigned RATE [5] = '{BAUD_300, BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  spso_cfg_t cfg;
  spso_scale_t scale;
  spso_word_t msg_word;
  logic key_print = 1'b0;
  logic remote_print_sw = 1'b0;
  logic msg_valid = 1'b0;
  logic msg_ready, print_start, print_busy, printer_txd, term_txd, term_rxd, rx_valid, rx_frame_err;
  logic [6:0] rx_char;
  logic [6:0] m[$];
  logic [31:0] div = 32'd20;
  int fails = 0;
  int check_count = 0;
  bit start_seen = 1'b0;
  bit rx_seen = 1'b0;

  always #2.5 core_clk = ~core_clk;

  spso_print_out #(.CLK_HZ(TB_CLK), .FIFO_DEPTH_P(FIFO_DEPTH)) u_spso_print_out (
    .core_clk(core_clk), .reset_n(reset_n), .cfg(cfg), .scale(scale), .key_print(key_print),
    .remote_print_sw(remote_print_sw), .term_rxd(term_rxd), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_word(msg_word), .print_start(print_start), .print_busy(print_busy), .printer_txd(printer_txd),
    .term_txd(term_txd), .rx_valid(rx_valid), .rx_char(rx_char), .rx_frame_err(rx_frame_err)
  );

  spso_serial_peer u_spso_serial_peer (
    .core_clk(core_clk), .txd(printer_txd), .bit_div(div), .rxd(term_rxd)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A one-cycle pulse is latched so no caller can miss it between waits
  always @(posedge core_clk)
    if (print_start === 1'b1)
      start_seen <= 1'b1;

  always @(posedge core_clk)
    if (rx_valid === 1'b1)
      rx_seen <= 1'b1;

  always @(negedge core_clk)
    if (reset_n)
      check("term_txd", term_txd, printer_txd);

  function automatic logic par_of(logic [6:0] ch);
    return (cfg.parity_choice_setting == PAR_ZERO) ? 1'b0 : (^ch ^ (cfg.parity_choice_setting == PAR_ODD));
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic press_key();
    key_print <= 1'b1;
    tick(1);
    key_print <= 1'b0;
  endtask

  task automatic no_start(input int n);
    start_seen = 1'b0;
    tick(n);
    check("no print_start", start_seen, 1'b0);
  endtask

  // Waits for the print, pushes m, then compares every frame on the line
  task automatic do_print(input logic [6:0] w[$]);
    logic [6:0] exp[$];
    logic [6:0] sum;
    int n;
    n = 0;
    while (start_seen !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    check("print_start", start_seen, 1'b1);
    check("print_busy high", print_busy, 1'b1);
    start_seen = 1'b0;
    u_spso_serial_peer.frames.delete();
    u_spso_serial_peer.lens.delete();
    if (cfg.checksum_enable_setting && !cfg.continuous_mode)
      exp.push_back(STX_CHAR);
    for (int i = 0; i < w.size(); i++)
    begin
      msg_valid <= 1'b1;
      msg_word <= '{msg_end: (i == w.size() - 1), cks_after: (i == w.size() - 2), chr: w[i]};
      n = 0;
      do
      begin
        tick(1);
        n++;
      end
      while (msg_ready !== 1'b1 && n < 20000);
      exp.push_back(w[i]);
      if (i == w.size() - 2 && cfg.checksum_enable_setting)
      begin
        sum = 7'h00;
        foreach (exp[k])
          sum += exp[k];
        exp.push_back(7'h00 - sum);
      end
      if (i == FIFO_DEPTH - 1)
      begin
        msg_valid <= 1'b0;
        tick(2);
        check("msg_ready full", msg_ready, 1'b0);
      end
    end
    msg_valid <= 1'b0;
    n = 0;
    while (u_spso_serial_peer.frames.size() < exp.size() && n < 12 * div * exp.size())
    begin
      tick(1);
      n++;
    end
    check("frame count", u_spso_serial_peer.frames.size(), exp.size());
    foreach (exp[k])
      check("frame", u_spso_serial_peer.frames[k], {1'b1, par_of(exp[k]), exp[k], 1'b0});
    n = 0;
    while (print_busy !== 1'b0 && n < 4 * div)
    begin
      tick(1);
      n++;
    end
    check("print_busy", print_busy, 1'b0);
    check("idle line", printer_txd, 1'b1);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #400us;
    fails++;
    final_report();
  end

  initial
  begin
    cfg = '{baud_rate_setting: BAUD_SEL_9600, parity_choice_setting: PAR_EVEN, checksum_enable_setting: 1'b1,
            autoprint_enable_setting: 1'b0, continuous_mode: 1'b0};
    scale = '{in_motion: 1'b0, below_gross_zero: 1'b0, expanded_mode: 1'b0, zero_captured: 1'b1,
              weight_half_d: 24'sh000000};
    msg_word = '0;
    tick(6);
    reset_n <= 1'b1;
    tick(3);
    // Seventeen words fill the FIFO and stall the last one while the leading character is sent
    for (int i = 0; i < 15; i++)
      m.push_back(7'h30 + 7'(i));
    m.push_back(7'h0d);
    m.push_back(7'h0a);
    press_key();
    do_print(m);
    cfg.checksum_enable_setting <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      cfg.baud_rate_setting <= spso_baud_t'(i);
      cfg.parity_choice_setting <= spso_parity_t'(i % 3);
      div <= TB_CLK / RATE[i];
      tick(3);
      m = {7'h41 + 7'(2 * i)};
      press_key();
      do_print(m);
      check("bit period", u_spso_serial_peer.lens[0], div);
    end
    m = {7'h58, 7'h0d};
    cfg.checksum_enable_setting <= 1'b1;
    scale.in_motion <= 1'b1;
    tick(1);
    press_key();
    no_start(60);
    scale.in_motion <= 1'b0;
    do_print(m);
    for (int k = 0; k < 3; k++)
    begin
      scale.below_gross_zero <= (k == 0);
      scale.expanded_mode <= (k == 1);
      scale.zero_captured <= (k != 2);
      tick(1);
      press_key();
      no_start(40);
    end
    scale.zero_captured <= 1'b1;
    no_start(40);
    remote_print_sw <= 1'b1;
    do_print(m);
    remote_print_sw <= 1'b0;
    rx_seen = 1'b0;
    u_spso_serial_peer.send_char(7'h50, 1'b1);
    check("rx_valid", rx_seen, 1'b1);
    check("rx_char", rx_char, 7'h50);
    check("rx_frame_err", rx_frame_err, 1'b0);
    do_print(m);
    start_seen = 1'b0;
    rx_seen = 1'b0;
    u_spso_serial_peer.send_char(7'h51, 1'b0);
    check("rx_valid", rx_seen, 1'b1);
    check("rx_frame_err", rx_frame_err, 1'b1);
    tick(40);
    check("no print_start", start_seen, 1'b0);
    cfg.checksum_enable_setting <= 1'b0;
    cfg.autoprint_enable_setting <= 1'b1;
    m = {7'h41};
    scale.weight_half_d <= 24'sd9;
    tick(1);
    no_start(40);
    scale.weight_half_d <= 24'sd10;
    do_print(m);
    no_start(60);
    scale.weight_half_d <= 24'sd2;
    tick(5);
    scale.weight_half_d <= 24'sd10;
    tick(1);
    no_start(40);
    scale.weight_half_d <= -24'sd1;
    tick(5);
    scale.in_motion <= 1'b1;
    scale.weight_half_d <= 24'sd10;
    tick(1);
    no_start(40);
    scale.in_motion <= 1'b0;
    do_print(m);
    scale.weight_half_d <= 24'sd0;
    cfg.continuous_mode <= 1'b1;
    cfg.checksum_enable_setting <= 1'b1;
    tick(5);
    scale.weight_half_d <= 24'sd12;
    m = {7'h43, 7'h0d};
    do_print(m);
    final_report();
  end
endmodule // spso_print_out_test
